// file: core/nvwg_top.sv
/*
 * Write guard: registers, unlock key, lockout, protection, sequencer.
 * Assumes same-clock arrays that answer reads at once and pulse mem_done.
 */
// Contract
// - Reset clears write permission.
// - Power-up lockout blocks writes.
// - Write needs permit and key.
// - Zero data fuse refuses programmer data access.
// - CPU access survives protection.
// - Flash rows erased whole.
// - Protected segments reject flash operations.
// - Hidden latches loaded through data pair.
// - Rows and latches: 32 aligned words.
// - Erased row programmable in parts.
// - Hardware clears start bits.
// - Start needs permit; no later abort.
// - Array write end sets done flag; latch-only loads do not.
// - Reset during write sets abort.
`timescale 1ns/1ps
`default_nettype none
module nvwg_top #(
    parameter int unsigned PWRT_CYCLES = nvwg_pkg::PWRT_CYCLES
) (
    // Clock and reset.
    input  wire logic                            clock,
    input  wire logic                            reset_n,
    // Register port.
    input  wire logic [nvwg_pkg::RADDR_W-1:0]    reg_addr,
    input  wire logic [nvwg_pkg::DATA_W-1:0]     reg_wdata,
    input  wire logic                            reg_we,
    input  wire logic                            reg_re,
    output logic      [nvwg_pkg::DATA_W-1:0]     reg_rdata,
    // Configuration pins.
    input  wire logic                            data_protect_fuse,
    input  wire logic                            code_protect_fuse,
    input  wire logic [1:0]                      self_write_protect_field,
    // External programmer.
    input  wire logic                            ext_data_req,
    input  wire logic                            ext_prog_req,
    output logic                                 ext_data_grant,
    output logic                                 ext_prog_grant,
    // Instruction fetch.
    input  wire logic                            fetch_slot,
    output logic                                 force_nop,
    // Array side.
    input  wire logic [nvwg_pkg::WORD_W-1:0]     mem_rdata,
    input  wire logic                            mem_done,
    input  wire logic                            mem_write_broken,
    input  wire logic [nvwg_pkg::ROW_IDX_W-1:0]  latch_rd_index,
    output logic      [nvwg_pkg::WORD_W-1:0]     latch_rd_data,
    output logic      [nvwg_pkg::PADDR_W-1:0]    mem_addr,
    output logic      [1:0]                      mem_space,
    output logic      [nvwg_pkg::DATA_W-1:0]     mem_wdata,
    output logic                                 mem_read,
    output logic                                 mem_byte_write,
    output logic                                 mem_erase_row,
    output logic                                 mem_prog_row
);
    // Registers of the programmer's model.
    logic [7:0] addr_lo_q, addr_lo_d, dat_lo_q, dat_lo_d;
    logic [6:0] addr_hi_q, addr_hi_d;
    logic [5:0] dat_hi_q, dat_hi_d;
    logic       pgd_q, pgd_d, config_space_select_q, config_space_select_d, lwlo_q, lwlo_d;
    logic       free_q, free_d, write_permit_q, write_permit_d;
    logic       wr_q, wr_d, rd_q, rd_d, abort_q, abort_d, done_q, done_d;
    logic       armed_q, armed_d;
    logic [7:0] rdata_d;
    nvwg_pkg::nvwg_state_e st_q, st_d;
    nvwg_pkg::nvwg_key_e   key_q, key_d;
    logic [nvwg_pkg::PWRT_W-1:0] pwrt_q, pwrt_d;
    logic       lock_q, lock_d;
    logic [4:0] sync1_q, sync2_q;
    logic       code_sync1_q, code_sync2_q, code_protect_q;
    logic       grant_d_d, grant_p_d;
    logic       rdm_d, bw_d, er_d, pr_d, nop_d;
    logic [14:0] maddr_d;
    logic       latch_load, latch_clear;
    logic       ctrl_we, key_we, start_req, start_ok, prot_hit, prog_sp;
    logic [14:0] full_addr;

    // Write latches.
    nvwg_latch u_latch (
        .clock      (clock),
        .reset_n    (reset_n),
        .load       (latch_load),
        .load_index (addr_lo_q[nvwg_pkg::ROW_IDX_W-1:0]),
        .load_data  ({dat_hi_q, dat_lo_q}),
        .clear      (latch_clear),
        .rd_index   (latch_rd_index),
        .rd_data    (latch_rd_data)
    );

    // Two-flop synchroniser for the pins.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {ext_prog_req, ext_data_req, self_write_protect_field,
                        data_protect_fuse};
            sync2_q <= sync1_q;
        end
    end

    // Programmer gates; a zero fuse refuses.
    always_comb begin
        grant_d_d = sync2_q[3] && sync2_q[0];
        grant_p_d = sync2_q[4] && code_protect_q;
    end

    // Decode helpers.
    always_comb begin
        ctrl_we   = reg_we && reg_addr == nvwg_pkg::OFF_CONTROL;
        key_we    = reg_we && reg_addr == nvwg_pkg::OFF_KEY;
        start_req = ctrl_we && reg_wdata[nvwg_pkg::CB_START];
        prog_sp   = pgd_q || config_space_select_q;
        full_addr = {addr_hi_q, addr_lo_q};
        unique case (sync2_q[2:1])
            nvwg_pkg::WP_NONE: prot_hit = 1'b0;
            nvwg_pkg::WP_LOW:  prot_hit = full_addr <= nvwg_pkg::WP_LOW_END;
            nvwg_pkg::WP_HALF: prot_hit = full_addr <= nvwg_pkg::WP_HALF_END;
            default:           prot_hit = 1'b1;
        endcase
        prot_hit = prot_hit && pgd_q && !config_space_select_q;
        start_ok = start_req && key_q == nvwg_pkg::NVWG_KEY_FULL
                   && write_permit_q && !lock_q
                   && st_q == nvwg_pkg::NVWG_IDLE && !rd_q && !wr_q
                   && !prot_hit;
    end

    // Unlock key tracker.
    always_comb begin
        key_d = key_q;
        if (reg_we || reg_re) begin
            key_d = nvwg_pkg::NVWG_KEY_NONE;
            if (key_we && reg_wdata == nvwg_pkg::KEY_FIRST) begin
                key_d = nvwg_pkg::NVWG_KEY_HALF;
            end
            if (key_we && reg_wdata == nvwg_pkg::KEY_SECOND &&
                key_q == nvwg_pkg::NVWG_KEY_HALF) begin
                key_d = nvwg_pkg::NVWG_KEY_FULL;
            end
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            key_q <= nvwg_pkg::NVWG_KEY_NONE;
        end else begin
            key_q <= key_d;
        end
    end

    // Power-up lockout timer.
    always_comb begin
        pwrt_d = pwrt_q;
        lock_d = lock_q;
        if (lock_q) begin
            if (pwrt_q == nvwg_pkg::PWRT_W'(PWRT_CYCLES - 1)) begin
                lock_d = 1'b0;
            end else begin
                pwrt_d = pwrt_q + 1'b1;
            end
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pwrt_q <= '0;
            lock_q <= 1'b1;
        end else begin
            pwrt_q <= pwrt_d;
            lock_q <= lock_d;
        end
    end

    // Sequencer and register file next values.
    always_comb begin
        addr_lo_d = addr_lo_q;
        addr_hi_d = addr_hi_q;
        dat_lo_d  = dat_lo_q;
        dat_hi_d  = dat_hi_q;
        pgd_d = pgd_q;
        config_space_select_d = config_space_select_q;
        lwlo_d = lwlo_q;
        free_d = free_q;
        write_permit_d = write_permit_q;
        wr_d = wr_q;
        rd_d = rd_q;
        abort_d = abort_q;
        done_d = done_q;
        armed_d = 1'b1;
        st_d = st_q;
        rdm_d = 1'b0;
        bw_d = 1'b0;
        er_d = 1'b0;
        pr_d = 1'b0;
        nop_d = 1'b0;
        latch_load = 1'b0;
        latch_clear = 1'b0;
        // Software writes.
        if (reg_we) begin
            unique case (reg_addr)
                nvwg_pkg::OFF_ADDR_LOW:  addr_lo_d = reg_wdata;
                nvwg_pkg::OFF_ADDR_HIGH: addr_hi_d = reg_wdata[6:0];
                nvwg_pkg::OFF_DATA_LOW:  dat_lo_d = reg_wdata;
                nvwg_pkg::OFF_DATA_HIGH: dat_hi_d = reg_wdata[5:0];
                nvwg_pkg::OFF_STATUS: begin
                    if (!reg_wdata[nvwg_pkg::SB_DONE]) begin
                        done_d = 1'b0;
                    end
                end
                nvwg_pkg::OFF_CONTROL: begin
                    write_permit_d  = reg_wdata[nvwg_pkg::CB_PERMIT];
                    abort_d = reg_wdata[nvwg_pkg::CB_ABORT];
                    if (st_q == nvwg_pkg::NVWG_IDLE && !wr_q && !rd_q) begin
                        pgd_d  = reg_wdata[nvwg_pkg::CB_PROG_SPACE];
                        config_space_select_d = reg_wdata[nvwg_pkg::CB_CFG_SPACE];
                        lwlo_d = reg_wdata[nvwg_pkg::CB_LATCH_ONLY];
                        free_d = reg_wdata[nvwg_pkg::CB_ROW_ERASE];
                        // Zeros written to the start bits are ignored.
                        rd_d = reg_wdata[nvwg_pkg::CB_READ] &&
                               !reg_wdata[nvwg_pkg::CB_START];
                    end
                    if (start_ok) begin
                        wr_d = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Report a write cut by reset.
        if (!armed_q && mem_write_broken) begin
            abort_d = 1'b1;
        end
        unique case (st_q)
            nvwg_pkg::NVWG_IDLE: begin
                if (rd_q && prog_sp) begin
                    st_d = nvwg_pkg::NVWG_RD_SLOT;
                end else if (rd_q) begin
                    rdm_d = 1'b1;
                    st_d = nvwg_pkg::NVWG_RD_CAP;
                end else if (wr_q && !prog_sp) begin
                    bw_d = 1'b1;
                    st_d = nvwg_pkg::NVWG_WR_BUSY;
                end else if (wr_q && free_q) begin
                    er_d = 1'b1;
                    st_d = nvwg_pkg::NVWG_WR_BUSY;
                end else if (wr_q && lwlo_q) begin
                    latch_load = 1'b1;
                    wr_d = 1'b0;
                end else if (wr_q) begin
                    latch_load = 1'b1;
                    pr_d = 1'b1;
                    st_d = nvwg_pkg::NVWG_WR_BUSY;
                end
            end
            nvwg_pkg::NVWG_RD_SLOT: begin
                if (fetch_slot) begin
                    rdm_d = 1'b1;
                    nop_d = 1'b1;
                    st_d = nvwg_pkg::NVWG_RD_CAP;
                end
            end
            nvwg_pkg::NVWG_RD_CAP: begin
                dat_lo_d = mem_rdata[7:0];
                if (prog_sp) begin
                    dat_hi_d = mem_rdata[13:8];
                end
                rd_d = 1'b0;
                st_d = nvwg_pkg::NVWG_IDLE;
            end
            nvwg_pkg::NVWG_WR_BUSY: begin
                // Dropping permission here does not stop the cycle.
                if (mem_done) begin
                    wr_d = 1'b0;
                    done_d = 1'b1;
                    free_d = 1'b0;
                    latch_clear = prog_sp && !free_q;
                    st_d = nvwg_pkg::NVWG_IDLE;
                end
            end
            default: st_d = nvwg_pkg::NVWG_IDLE;
        endcase
        // Row operations use the row base.
        maddr_d = full_addr;
        if (prog_sp && (free_q || !lwlo_q)) begin
            maddr_d[4:0] = nvwg_pkg::ROW_BASE;
        end
    end

    // Read data, answered one cycle after the read strobe.
    always_comb begin
        rdata_d = 8'h00;
        if (reg_re) begin
            unique case (reg_addr)
                nvwg_pkg::OFF_ADDR_LOW:  rdata_d = addr_lo_q;
                nvwg_pkg::OFF_ADDR_HIGH: rdata_d = {1'b0, addr_hi_q};
                nvwg_pkg::OFF_DATA_LOW:  rdata_d = dat_lo_q;
                nvwg_pkg::OFF_DATA_HIGH: rdata_d = {2'h0, dat_hi_q};
                nvwg_pkg::OFF_CONTROL:   rdata_d = {pgd_q, config_space_select_q, free_q,
                    lwlo_q, abort_q, write_permit_q, wr_q, rd_q};
                nvwg_pkg::OFF_STATUS:    rdata_d = {5'h00,
                    st_q != nvwg_pkg::NVWG_IDLE, lock_q, done_q};
                default:                 rdata_d = 8'h00;
            endcase
        end
    end

    // State and output flops.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            addr_lo_q <= 8'h00;
            addr_hi_q <= 7'h00;
            dat_lo_q <= 8'h00;
            dat_hi_q <= 6'h00;
            pgd_q <= 1'b0;
            config_space_select_q <= 1'b0;
            lwlo_q <= 1'b0;
            free_q <= 1'b0;
            write_permit_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            abort_q <= 1'b0;
            done_q <= 1'b0;
            armed_q <= 1'b0;
            st_q <= nvwg_pkg::NVWG_IDLE;
            reg_rdata <= 8'h00;
            ext_data_grant <= 1'b0;
            ext_prog_grant <= 1'b0;
            force_nop <= 1'b0;
            mem_addr <= 15'h0000;
            mem_space <= 2'h0;
            mem_wdata <= 8'h00;
            mem_read <= 1'b0;
            mem_byte_write <= 1'b0;
            mem_erase_row <= 1'b0;
            mem_prog_row <= 1'b0;
            code_protect_q <= 1'b0;
        end else begin
            addr_lo_q <= addr_lo_d;
            addr_hi_q <= addr_hi_d;
            dat_lo_q <= dat_lo_d;
            dat_hi_q <= dat_hi_d;
            pgd_q <= pgd_d;
            config_space_select_q <= config_space_select_d;
            lwlo_q <= lwlo_d;
            free_q <= free_d;
            write_permit_q <= write_permit_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            abort_q <= abort_d;
            done_q <= done_d;
            armed_q <= armed_d;
            st_q <= st_d;
            reg_rdata <= rdata_d;
            ext_data_grant <= grant_d_d;
            ext_prog_grant <= grant_p_d;
            force_nop <= nop_d;
            mem_addr <= maddr_d;
            mem_space <= {config_space_select_q, pgd_q};
            mem_wdata <= dat_lo_q;
            mem_read <= rdm_d;
            mem_byte_write <= bw_d;
            mem_erase_row <= er_d;
            mem_prog_row <= pr_d;
            code_protect_q <= code_sync2_q;
        end
    end

    // Code fuse synchroniser.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            code_sync1_q <= 1'b0;
            code_sync2_q <= 1'b0;
        end else begin
            code_sync1_q <= code_protect_fuse;
            code_sync2_q <= code_sync1_q;
        end
    end
endmodule
`default_nettype wire

// file: core/nvwg_pkg.sv
/*
 * Constants of the write guard: register map, bits, keys, row layout.
 * Assumes one 200 MHz clock and an 8-bit register port.
 */
package nvwg_pkg;
    // Register port.
    localparam int          DATA_W       = 8;
    localparam int          RADDR_W      = 3;
    localparam logic [2:0]  OFF_ADDR_LOW = 3'h0;
    localparam logic [2:0]  OFF_ADDR_HIGH = 3'h1;
    localparam logic [2:0]  OFF_DATA_LOW = 3'h2;
    localparam logic [2:0]  OFF_DATA_HIGH = 3'h3;
    localparam logic [2:0]  OFF_CONTROL  = 3'h4;
    localparam logic [2:0]  OFF_KEY      = 3'h5;
    localparam logic [2:0]  OFF_STATUS   = 3'h6;

    // Control register bit positions.
    localparam int          CB_READ      = 0;
    localparam int          CB_START     = 1;
    localparam int          CB_PERMIT    = 2;
    localparam int          CB_ABORT     = 3;
    localparam int          CB_LATCH_ONLY = 4;
    localparam int          CB_ROW_ERASE = 5;
    localparam int          CB_CFG_SPACE = 6;
    localparam int          CB_PROG_SPACE = 7;

    // Status register bit positions.
    localparam int          SB_DONE      = 0;
    localparam int          SB_LOCKOUT   = 1;
    localparam int          SB_BUSY      = 2;

    // Unlock key values, in order.
    localparam logic [7:0]  KEY_FIRST    = 8'h55;
    localparam logic [7:0]  KEY_SECOND   = 8'hAA;

    // Flash word, address and row layout.
    localparam int          WORD_W       = 14;
    localparam int          HIGH_W       = 6;
    localparam int          AHIGH_W      = 7;
    localparam int          PADDR_W      = 15;
    localparam int          ROW_WORDS    = 32;
    localparam int          ROW_IDX_W    = 5;
    localparam logic [13:0] LATCH_ERASED = 14'h3FFF;
    localparam logic [4:0]  ROW_BASE     = 5'h00;

    // Protection codes and bounds.
    localparam logic [1:0]  WP_NONE      = 2'h3;
    localparam logic [1:0]  WP_LOW       = 2'h2;
    localparam logic [1:0]  WP_HALF      = 2'h1;
    localparam logic [14:0] WP_LOW_END   = 15'h01FF;
    localparam logic [14:0] WP_HALF_END  = 15'h0FFF;

    // Power-up timer.
    localparam int          CLK_KHZ      = 200000;
    localparam int          PWRT_MS      = 64;
    localparam int          PWRT_CYCLES  = PWRT_MS * CLK_KHZ;
    localparam int          PWRT_W       = 24;

    // Sequencer and key states.
    typedef enum logic [2:0] {
        NVWG_IDLE, NVWG_RD_SLOT, NVWG_RD_CAP, NVWG_WR_BUSY
    } nvwg_state_e;
    typedef enum logic [1:0] {
        NVWG_KEY_NONE, NVWG_KEY_HALF, NVWG_KEY_FULL
    } nvwg_key_e;
endpackage

// file: core/nvwg_latch.sv
/*
 * Flash write latches: one word per row slot, loaded by index.
 * Assumes load and clear come from the guard on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module nvwg_latch (
    // Clock and reset.
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    // Load and clear.
    input  wire logic                          load,
    input  wire logic [nvwg_pkg::ROW_IDX_W-1:0] load_index,
    input  wire logic [nvwg_pkg::WORD_W-1:0]   load_data,
    input  wire logic                          clear,
    // Read port toward the array.
    input  wire logic [nvwg_pkg::ROW_IDX_W-1:0] rd_index,
    output logic      [nvwg_pkg::WORD_W-1:0]   rd_data
);
    logic [nvwg_pkg::WORD_W-1:0] word_q [nvwg_pkg::ROW_WORDS];
    logic [nvwg_pkg::WORD_W-1:0] word_d [nvwg_pkg::ROW_WORDS];
    logic [nvwg_pkg::WORD_W-1:0] rd_d;

    // Latches reachable only through load, clear and the read port.
    genvar i;
    generate
        for (i = 0; i < nvwg_pkg::ROW_WORDS; i++) begin : g_word
            always_comb begin
                word_d[i] = word_q[i];
                if (clear) begin
                    word_d[i] = nvwg_pkg::LATCH_ERASED;
                end else if (load &&
                             load_index == nvwg_pkg::ROW_IDX_W'(i)) begin
                    // Only the indexed latch takes the word.
                    word_d[i] = load_data;
                end
            end
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    word_q[i] <= nvwg_pkg::LATCH_ERASED;
                end else begin
                    word_q[i] <= word_d[i];
                end
            end
        end
    endgenerate

    // Registered read of the indexed latch.
    always_comb begin
        rd_d = word_q[rd_index];
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= nvwg_pkg::LATCH_ERASED;
        end else begin
            rd_data <= rd_d;
        end
    end
endmodule
`default_nettype wire

// file: bench/nvwg_monitor.sv
/* Port checker for the guard.
   Assumes pins stay steady around each operation. */
`timescale 1ns/1ps
`default_nettype none
module nvwg_monitor #(
    parameter int unsigned PWRT_CYCLES = 16
) (
    // Clock, reset and register port.
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_we,
    // Pins and fetch.
    input wire logic       data_protect_fuse,
    input wire logic [1:0] self_write_protect_field,
    input wire logic       ext_data_req,
    input wire logic       ext_data_grant,
    input wire logic       fetch_slot,
    input wire logic       force_nop,
    // Array side.
    input wire logic [14:0] mem_addr,
    input wire logic [1:0] mem_space,
    input wire logic       mem_read,
    input wire logic       mem_byte_write,
    input wire logic       mem_erase_row,
    input wire logic       mem_prog_row
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Decoded strobes.
    wire logic ctl_w = reg_we && reg_addr == nvwg_pkg::OFF_CONTROL;
    wire logic key_w = reg_we && reg_addr == nvwg_pkg::OFF_KEY;
    wire logic row = mem_erase_row | mem_prog_row;
    wire logic pulse = mem_byte_write | row;
    wire logic [1:0] f = self_write_protect_field;
    logic [31:0] up_q, up_d;
    // Cycles since reset release, saturating.
    always_comb up_d = (up_q < PWRT_CYCLES) ? up_q + 32'h1 : up_q;
    always_ff @(posedge clock or negedge reset_n)
        if (!reset_n)
            up_q <= '0;
        else
            up_q <= up_d;
    AST_LOCKOUT: assert property (pulse |-> up_q >= PWRT_CYCLES)
        else $error("write pulse during power-up lockout");
    AST_KEY: assert property (pulse |->
        $past(ctl_w && reg_wdata[nvwg_pkg::CB_START], 2) &&
        $past(key_w && reg_wdata == nvwg_pkg::KEY_SECOND, 3) &&
        $past(key_w && reg_wdata == nvwg_pkg::KEY_FIRST, 4))
        else $error("write pulse without the unlock key");
    AST_ONE_SHOT: assert property (pulse |=> !pulse [*3])
        else $error("second write pulse from one key");
    AST_ROW_BASE: assert property (row |-> mem_addr[4:0] == 5'h00)
        else $error("row operation not row aligned");
    AST_PROTECT: assert property (row && mem_space == 2'h1 |->
        f == nvwg_pkg::WP_NONE ||
        (f == nvwg_pkg::WP_LOW && mem_addr > nvwg_pkg::WP_LOW_END) ||
        (f == nvwg_pkg::WP_HALF && mem_addr > nvwg_pkg::WP_HALF_END))
        else $error("flash operation on protected segment");
    AST_GRANT: assert property (ext_data_grant |->
        $past(ext_data_req, 3) && $past(data_protect_fuse, 3))
        else $error("programmer granted protected data");
    AST_CPU_READ: assert property (ctl_w && reg_wdata[0] &&
        reg_wdata[7:6] == 2'h0 |-> ##2 mem_read)
        else $error("data read not issued");
    AST_NOP: assert property (force_nop |->
        mem_read && $past(fetch_slot))
        else $error("forced nop outside the read slot");
endmodule
bind nvwg_top nvwg_monitor #(.PWRT_CYCLES(PWRT_CYCLES)) mon (
    .clock, .reset_n, .reg_addr, .reg_wdata, .reg_we, .data_protect_fuse,
    .self_write_protect_field, .ext_data_req, .ext_data_grant, .fetch_slot,
    .force_nop, .mem_addr, .mem_space, .mem_read, .mem_byte_write,
    .mem_erase_row, .mem_prog_row);
`default_nettype wire

// file: bench/nvwg_top_tb_top.sv
/* Self-checking bench for the guard.
   Assumes package, design and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module nvwg_top_tb_top;
    // Driven pins and observed outputs.
    logic clock = 0, reset_n = 0, reg_we = 0, reg_re = 0, fetch_slot = 0;
    logic dfuse = 1, ext_data_req = 0, mem_done = 0, broken = 0, got;
    logic [2:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, q, ad, dl, dh, pw;
    logic [1:0] wfield = 2'h3;
    logic [13:0] mem_rdata = 0;
    logic [4:0] lidx = 0;
    logic [14:0] pa;
    wire logic [7:0] reg_rdata, mem_wdata;
    wire logic [13:0] latch_rd_data;
    wire logic [14:0] mem_addr;
    wire logic [1:0] mem_space;
    wire logic grant, pg, nop, mem_read, mbw, mer, mpr;
    int fails = 0, checks = 0, seed = 57148;
    always #2.5 clock = ~clock;
    nvwg_top #(.PWRT_CYCLES(16)) uut (
        .clock, .reset_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .data_protect_fuse(dfuse), .code_protect_fuse(dfuse),
        .self_write_protect_field(wfield), .ext_data_req,
        .ext_prog_req(ext_data_req), .ext_data_grant(grant),
        .ext_prog_grant(pg), .fetch_slot, .force_nop(nop), .mem_rdata,
        .mem_done,
        .mem_write_broken(broken), .latch_rd_index(lidx), .latch_rd_data,
        .mem_addr, .mem_space, .mem_wdata, .mem_read,
        .mem_byte_write(mbw), .mem_erase_row(mer), .mem_prog_row(mpr));
    task automatic check(string what, logic [16:0] seen, logic [16:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        reg_re <= 1'b0;
        @(posedge clock);
    endtask
    task automatic idle(int n);
        reg_we <= 1'b0;
        reg_re <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    task automatic rd(logic [2:0] a);
        reg_addr <= a;
        reg_we <= 1'b0;
        reg_re <= 1'b1;
        @(posedge clock);
        reg_re <= 1'b0;
        @(negedge clock);
        q = reg_rdata;
        @(posedge clock);
    endtask
    // Unlock key before a control write; permit first.
    task automatic start(logic [7:0] ctl);
        wr(nvwg_pkg::OFF_CONTROL, ctl & 8'hFD);
        wr(nvwg_pkg::OFF_KEY, nvwg_pkg::KEY_FIRST);
        wr(nvwg_pkg::OFF_KEY, nvwg_pkg::KEY_SECOND);
        wr(nvwg_pkg::OFF_CONTROL, ctl);
        idle(1);
    endtask
    // Watches for an array pulse, then answers it with mem_done.
    task automatic wait_pulse();
        got = 0;
        repeat (8) begin
            @(negedge clock);
            if ((mbw | mer | mpr) === 1'b1) begin
                got = 1;
                pa = mem_addr;
                pw = mem_wdata;
            end
        end
        @(posedge clock);
        mem_done <= got;
        idle(1);
        mem_done <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Main sequence of scenarios.
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        rd(nvwg_pkg::OFF_CONTROL);
        check("control", q, 8'h00);
        rd(nvwg_pkg::OFF_STATUS);
        check("lockout", q[1], 1'b1);
        start(8'h06);
        wait_pulse();
        check("locked write", got, 1'b0);
        idle(20);
        start(8'h02);
        wait_pulse();
        check("no permit", got, 1'b0);
        ad = 8'($random(seed));
        dl = 8'($random(seed));
        wr(nvwg_pkg::OFF_ADDR_LOW, ad);
        wr(nvwg_pkg::OFF_DATA_LOW, dl);
        start(8'h06);
        wait_pulse();
        check("byte write", {got, pa[7:0], pw}, {1'b1, ad, dl});
        rd(nvwg_pkg::OFF_STATUS);
        check("done", q[0], 1'b1);
        rd(nvwg_pkg::OFF_CONTROL);
        check("start clear", q[1], 1'b0);
        wr(nvwg_pkg::OFF_STATUS, 8'h00);
        wr(nvwg_pkg::OFF_KEY, nvwg_pkg::KEY_FIRST);
        rd(nvwg_pkg::OFF_ADDR_LOW);
        start(8'h06);
        wait_pulse();
        check("key kept", got, 1'b1);
        wr(nvwg_pkg::OFF_KEY, nvwg_pkg::KEY_FIRST);
        rd(nvwg_pkg::OFF_ADDR_LOW);
        wr(nvwg_pkg::OFF_KEY, nvwg_pkg::KEY_SECOND);
        wr(nvwg_pkg::OFF_CONTROL, 8'h06);
        idle(1);
        wait_pulse();
        check("split key", got, 1'b0);
        dfuse <= 1'b0;
        ext_data_req <= 1'b1;
        mem_rdata <= 14'($random(seed));
        wr(nvwg_pkg::OFF_CONTROL, 8'h01);
        idle(6);
        check("grant shut", {grant, pg}, 2'b00);
        rd(nvwg_pkg::OFF_DATA_LOW);
        check("cpu read", q, mem_rdata[7:0]);
        dfuse <= 1'b1;
        idle(6);
        check("grant open", {grant, pg}, 2'b11);
        wr(nvwg_pkg::OFF_CONTROL, 8'h81);
        idle(3);
        fetch_slot <= 1'b1;
        @(posedge clock);
        fetch_slot <= 1'b0;
        @(negedge clock);
        check("forced nop", {nop, mem_read}, 2'b11);
        @(posedge clock);
        rd(nvwg_pkg::OFF_DATA_HIGH);
        check("word high", q, {2'b00, mem_rdata[13:8]});
        wr(nvwg_pkg::OFF_ADDR_HIGH, 8'h01);
        wr(nvwg_pkg::OFF_ADDR_LOW, 8'h07);
        for (int f = 3; f >= 0; f--) begin
            wfield <= 2'(f);
            start(8'hA6);
            wait_pulse();
            check("guarded erase", got, f == 3);
        end
        check("row base", pa, 15'h0100);
        wfield <= 2'h3;
        dh = 8'($random(seed));
        wr(nvwg_pkg::OFF_ADDR_LOW, 8'h05);
        wr(nvwg_pkg::OFF_DATA_HIGH, dh);
        start(8'h96);
        lidx <= 5'h05;
        idle(4);
        check("latch", latch_rd_data, {dh[5:0], mem_rdata[7:0]});
        start(8'h86);
        wait_pulse();
        check("row prog", {mpr, got, pa}, {2'b01, 15'h0100});
        broken <= 1'b1;
        reset_n <= 1'b0;
        idle(3);
        reset_n <= 1'b1;
        idle(2);
        broken <= 1'b0;
        rd(nvwg_pkg::OFF_CONTROL);
        check("abort", q, 8'h08);
        print_verdict();
    end
    // Watchdog against a hung handshake.
    initial begin
        #20000;
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
